// *** rtl/mpa_defs.svh ***
`ifndef MPA_DEFS_SVH
`define MPA_DEFS_SVH

// Function codes and the exception flag added to them
`define MPA_FC_READ      8'h03
`define MPA_FC_WRITE     8'h10
`define MPA_FC_EXC       8'h80

// Standard exception codes
`define MPA_EX_NONE      8'h00
`define MPA_EX_ILL_FUNC  8'h01
`define MPA_EX_ILL_ADDR  8'h02
`define MPA_EX_ILL_VALUE 8'h03
`define MPA_EX_DEV_FAIL  8'h04
`define MPA_EX_ACK       8'h05
`define MPA_EX_BUSY      8'h06
`define MPA_EX_PARITY    8'h08
`define MPA_EX_GW_PATH   8'h0a
`define MPA_EX_GW_SILENT 8'h0b

// Maker exception codes
`define MPA_EX_BLOCK     8'h20
`define MPA_EX_UNKNOWN   8'h21
`define MPA_EX_PROCESS   8'h22
`define MPA_EX_BYTECNT   8'h23

// Transport
`define MPA_TCP_PORT     16'h01f6
`define MPA_CONN_MAX     2'h2

// Register quantities
`define MPA_QTY_SINGLE   16'h0001
`define MPA_QTY_32       16'h0002
`define MPA_QTY_64       16'h0004

// Byte positions inside a request
`define MPA_POS_FC       8'h00
`define MPA_POS_ADDR_HI  8'h01
`define MPA_POS_ADDR_LO  8'h02
`define MPA_POS_QTY_HI   8'h03
`define MPA_POS_QTY_LO   8'h04
`define MPA_POS_BCNT     8'h05
`define MPA_POS_DATA     8'h06
`define MPA_CNT_MAX      8'hff

// Response frame layout
`define MPA_FRAME_BYTES  13
`define MPA_LEN_EXC      4'h2
`define MPA_LEN_ECHO     4'h5
`define MPA_LEN_RHDR     4'h2
`define MPA_QTY_MAXREG   3'h4

// Float scaling
`define MPA_SCALE        64'h00000000000003e8
`define MPA_DIV_STEPS    7'h40

`endif

// *** rtl/mpa_pkg.sv ***
package mpa_pkg;
`include "mpa_defs.svh"

	// Request handler states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_RECV  = 8'h02,
		ST_CHECK = 8'h04,
		ST_LOOK  = 8'h08,
		ST_DIV   = 8'h10,
		ST_ACC   = 8'h20,
		ST_RESP  = 8'h40,
		ST_SEND  = 8'h80
	} mpa_state_type;

	// Sign extension from the width the register quantity implies
	function automatic logic [63:0] mpa_sext(input logic [63:0] v, input logic [15:0] qty);
		logic [63:0] r;
		r = v;
		if (qty == `MPA_QTY_SINGLE) begin
			r = {{48{v[15]}}, v[15:0]};
		end else if (qty == `MPA_QTY_32) begin
			r = {{32{v[31]}}, v[31:0]};
		end
		return r;
	endfunction

	// Byte count that belongs to a register quantity
	function automatic logic [8:0] mpa_qty_bytes(input logic [15:0] qty);
		return {qty[7:0], 1'b0};
	endfunction

endpackage

// *** rtl/mpa_div1000.sv ***
`timescale 1ns/100ps
`include "mpa_defs.svh"

// Signed division by the float scale factor, one quotient bit per clock
module mpa_div1000 (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// Operation
	input  wire logic        start_i,
	input  wire logic [63:0] dividend_i,
	output logic             done_o,
	output logic [63:0]      quot_o
);
	import mpa_pkg::*;

	logic [6:0]  cnt_q,  cnt_d;
	logic [63:0] rem_q,  rem_d;
	logic [63:0] quo_q,  quo_d;
	logic [63:0] res_q,  res_d;
	logic        neg_q,  neg_d;
	logic        done_q, done_d;
	logic [63:0] trial;

	// Restoring divide on the magnitude; a full 64-step pass trades speed for area
	always_comb begin
		cnt_d  = cnt_q;
		rem_d  = rem_q;
		quo_d  = quo_q;
		res_d  = res_q;
		neg_d  = neg_q;
		done_d = 1'b0;
		trial  = {rem_q[62:0], quo_q[63]};
		if (start_i) begin
			neg_d = dividend_i[63];
			quo_d = dividend_i[63] ? 64'(-dividend_i) : dividend_i;
			rem_d = 64'h0;
			cnt_d = `MPA_DIV_STEPS;
		end else if (cnt_q != 7'h0) begin
			cnt_d = cnt_q - 7'h01;
			if (trial >= `MPA_SCALE) begin
				rem_d = trial - `MPA_SCALE;
				quo_d = {quo_q[62:0], 1'b1};
			end else begin
				rem_d = trial;
				quo_d = {quo_q[62:0], 1'b0};
			end
			if (cnt_q == 7'h01) begin
				res_d  = neg_q ? 64'(-quo_d) : quo_d;
				done_d = 1'b1;
			end
		end
	end

	// Divider registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q  <= 7'h0;
			rem_q  <= 64'h0;
			quo_q  <= 64'h0;
			res_q  <= 64'h0;
			neg_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			rem_q  <= rem_d;
			quo_q  <= quo_d;
			res_q  <= res_d;
			neg_q  <= neg_d;
			done_q <= done_d;
		end
	end

	assign done_o = done_q;
	assign quot_o = res_q;

endmodule

// *** rtl/mpa_tx.sv ***
`timescale 1ns/100ps
`include "mpa_defs.svh"

// Response serializer: holds one response frame and shifts it out byte-wise
module mpa_tx (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// Frame load
	input  wire logic         load_i,
	input  wire logic [3:0]   len_i,
	input  wire logic [103:0] frame_i,
	input  wire logic [1:0]   conn_i,
	output logic              done_o,
	// Byte stream
	output logic              tx_valid_o,
	output logic [7:0]        tx_data_o,
	output logic              tx_last_o,
	output logic [1:0]        tx_conn_o,
	input  wire logic         tx_ready_i
);
	import mpa_pkg::*;

	logic [7:0] mem_q [`MPA_FRAME_BYTES];
	logic [7:0] mem_d [`MPA_FRAME_BYTES];
	logic [3:0] len_q,  len_d;
	logic [1:0] conn_q, conn_d;
	logic       take;

	assign take = tx_valid_o && tx_ready_i;

	// Byte 0 always sits at the head so the data output comes straight from a flop
	always_comb begin
		mem_d  = mem_q;
		len_d  = len_q;
		conn_d = conn_q;
		if (load_i) begin
			for (int i = 0; i < `MPA_FRAME_BYTES; i++) begin
				mem_d[i] = frame_i[103 - 8*i -: 8];
			end
			len_d  = len_i;
			conn_d = conn_i;
		end else if (take) begin
			for (int i = 0; i < `MPA_FRAME_BYTES - 1; i++) begin
				mem_d[i] = mem_q[i + 1];
			end
			mem_d[`MPA_FRAME_BYTES - 1] = 8'h00;
			len_d = len_q - 4'h1;
		end
	end

	// Frame registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < `MPA_FRAME_BYTES; i++) begin
				mem_q[i] <= 8'h00;
			end
			len_q  <= 4'h0;
			conn_q <= 2'h0;
		end else begin
			mem_q  <= mem_d;
			len_q  <= len_d;
			conn_q <= conn_d;
		end
	end

	assign tx_valid_o = (len_q != 4'h0);
	assign tx_data_o  = mem_q[0];
	assign tx_last_o  = (len_q == 4'h1);
	assign tx_conn_o  = conn_q;
	assign done_o     = take && tx_last_o;

endmodule

// *** rtl/mpa_top.sv ***
`timescale 1ns/100ps
`include "mpa_defs.svh"

// Functional notes
// - Only function codes 0x03 and 0x10 are served; others get an exception.
// - Parameters up to 32 bits take two registers, accessed together.
// - 64-bit parameters take four registers, accessed together in one message.
// - Wrong register quantity gives an exception; some parameters allow one register.
// - Float values are multiplied by 1000 when read, divided when written.
// - Writing a value-less command executes it, data dropped; reading returns zero.
// - Read reply carries 0x03, byte count twice quantity, then register bytes.
// - Write reply echoes 0x10, start address and quantity, without data.
// - Failures answer the function code with 0x80 added (0x83, 0x90, 0x84 for 0x04) followed by one exception code byte.
// - Standard exception codes 1 to 6, 8, 10 and 11 are defined.
// - Quantity not matching parameter width returns maker code 32.
// - Unknown address returns code 33; failed processing returns code 34.
// - Inconsistent byte count field in a write returns code 35.
// - Most significant word first, each register high byte first.
// - Requests are served on TCP port 502 with no CRC.
// - Up to three master connections are served.
// - String-output commands are not reachable through registers.
module mpa_top (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// Request bytes from the transport
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_last_i,
	input  wire logic [1:0]  rx_conn_i,
	input  wire logic [15:0] rx_port_i,
	output logic             rx_ready_o,
	// Response bytes to the transport
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	output logic             tx_last_o,
	output logic [1:0]       tx_conn_o,
	input  wire logic        tx_ready_i,
	// Parameter lookup
	output logic             look_req_o,
	output logic [15:0]      look_addr_o,
	input  wire logic        look_ack_i,
	input  wire logic        look_found_i,
	input  wire logic        look_wide_i,
	input  wire logic        look_single_i,
	input  wire logic        look_float_i,
	input  wire logic        look_cmd_i,
	input  wire logic        look_string_i,
	// Parameter access
	output logic             acc_req_o,
	output logic             acc_we_o,
	output logic             acc_exec_o,
	output logic [15:0]      acc_addr_o,
	output logic [63:0]      acc_wdata_o,
	input  wire logic        acc_ack_i,
	input  wire logic        acc_err_i,
	input  wire logic [63:0] acc_rdata_i
);
	import mpa_pkg::*;

	mpa_state_type state_q, state_d;
	logic [7:0]    cnt_q,   cnt_d;
	logic [7:0]    fc_q,    fc_d;
	logic [15:0]   addr_q,  addr_d;
	logic [15:0]   qty_q,   qty_d;
	logic [7:0]    bc_q,    bc_d;
	logic [63:0]   data_q,  data_d;
	logic [1:0]    conn_q,  conn_d;
	logic          drop_q,  drop_d;
	logic          float_q, float_d;
	logic          we_q,    we_d;
	logic          exec_q,  exec_d;
	logic [7:0]    exc_q,   exc_d;
	logic [63:0]   wdata_q, wdata_d;
	logic [63:0]   rdata_q, rdata_d;

	logic          rx_take;
	logic [7:0]    pos;
	logic          is_read;
	logic          is_write;
	logic          size_ok;
	logic          div_start;
	logic          div_done;
	logic [63:0]   div_quot;
	logic          tx_load;
	logic          tx_done;
	logic [3:0]    tx_len;
	logic [103:0]  tx_frame;
	logic [63:0]   rd_aligned;
	logic [63:0]   rd_value;

	// Intake is open only while idle or receiving a request, which holds back all connections
	assign rx_ready_o = (state_q == ST_IDLE) || (state_q == ST_RECV);
	assign rx_take    = rx_valid_i && rx_ready_o;
	assign pos        = (state_q == ST_IDLE) ? `MPA_POS_FC : cnt_q;
	assign is_read    = (fc_q == `MPA_FC_READ);
	assign is_write   = (fc_q == `MPA_FC_WRITE);

	// Block size check against the parameter width
	always_comb begin
		if (look_wide_i) begin
			size_ok = (qty_q == `MPA_QTY_64);
		end else begin
			size_ok = (qty_q == `MPA_QTY_32)
				|| (look_single_i && (qty_q == `MPA_QTY_SINGLE));
		end
	end

	// Value read back, sign-extended from the register quantity and scaled for floats
	always_comb begin
		rd_value = mpa_sext(acc_rdata_i, qty_q);
		if (float_q) begin
			rd_value = 64'(rd_value * `MPA_SCALE);
		end
	end

	// Request parser and sequencer
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		fc_d      = fc_q;
		addr_d    = addr_q;
		qty_d     = qty_q;
		bc_d      = bc_q;
		data_d    = data_q;
		conn_d    = conn_q;
		drop_d    = drop_q;
		float_d   = float_q;
		we_d      = we_q;
		exec_d    = exec_q;
		exc_d     = exc_q;
		wdata_d   = wdata_q;
		rdata_d   = rdata_q;
		div_start = 1'b0;
		tx_load   = 1'b0;
		case (state_q)
			ST_IDLE, ST_RECV: begin
				if (rx_take) begin
					// Frame ends on the transport's last flag; no CRC is expected
					if (pos == `MPA_POS_FC) begin
						fc_d   = rx_data_i;
						conn_d = rx_conn_i;
						drop_d = (rx_port_i != `MPA_TCP_PORT)
							|| (rx_conn_i > `MPA_CONN_MAX);
						data_d = 64'h0;
						bc_d   = 8'h00;
						qty_d  = 16'h0000;
						addr_d = 16'h0000;
						exc_d  = `MPA_EX_NONE;
					end else if (pos == `MPA_POS_ADDR_HI) begin
						addr_d[15:8] = rx_data_i;
					end else if (pos == `MPA_POS_ADDR_LO) begin
						addr_d[7:0] = rx_data_i;
					end else if (pos == `MPA_POS_QTY_HI) begin
						qty_d[15:8] = rx_data_i;
					end else if (pos == `MPA_POS_QTY_LO) begin
						qty_d[7:0] = rx_data_i;
					end else if (pos == `MPA_POS_BCNT) begin
						bc_d = rx_data_i;
					end else begin
						data_d = {data_q[55:0], rx_data_i};
					end
					cnt_d   = (pos == `MPA_CNT_MAX) ? pos : pos + 8'h01;
					state_d = rx_last_i ? ST_CHECK : ST_RECV;
				end
			end
			ST_CHECK: begin
				cnt_d   = 8'h00;
				state_d = ST_RESP;
				if (drop_q) begin
					state_d = ST_IDLE;
				end else if (!is_read && !is_write) begin
					exc_d = `MPA_EX_ILL_FUNC;
				end else if (is_read && (cnt_q != `MPA_POS_BCNT)) begin
					exc_d = `MPA_EX_ILL_VALUE;
				end else if (is_write && (cnt_q < `MPA_POS_DATA)) begin
					exc_d = `MPA_EX_ILL_VALUE;
				end else if (is_write && (({1'b0, bc_q} != mpa_qty_bytes(qty_q))
						|| (qty_q[15:8] != 8'h00)
						|| ({1'b0, cnt_q} != ({1'b0, `MPA_POS_DATA} + {1'b0, bc_q})))) begin
					exc_d = `MPA_EX_BYTECNT;
				end else begin
					state_d = ST_LOOK;
				end
			end
			ST_LOOK: begin
				if (look_ack_i) begin
					float_d = look_float_i;
					we_d    = is_write;
					exec_d  = 1'b0;
					wdata_d = mpa_sext(data_q, qty_q);
					state_d = ST_RESP;
					if (!look_found_i || look_string_i) begin
						exc_d = `MPA_EX_UNKNOWN;
					end else if (!size_ok) begin
						exc_d = `MPA_EX_BLOCK;
					end else if (look_cmd_i && is_read) begin
						rdata_d = 64'h0;
					end else if (look_cmd_i) begin
						exec_d  = 1'b1;
						we_d    = 1'b0;
						wdata_d = 64'h0;
						state_d = ST_ACC;
					end else if (is_write && look_float_i) begin
						div_start = 1'b1;
						state_d   = ST_DIV;
					end else begin
						state_d = ST_ACC;
					end
				end
			end
			ST_DIV: begin
				if (div_done) begin
					wdata_d = div_quot;
					state_d = ST_ACC;
				end
			end
			ST_ACC: begin
				if (acc_ack_i) begin
					state_d = ST_RESP;
					if (acc_err_i) begin
						exc_d = `MPA_EX_PROCESS;
					end else if (is_read) begin
						rdata_d = rd_value;
					end
				end
			end
			ST_RESP: begin
				tx_load = 1'b1;
				state_d = ST_SEND;
			end
			ST_SEND: begin
				if (tx_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Response frame, first byte on the left
	always_comb begin
		rd_aligned = rdata_q << {(`MPA_QTY_MAXREG - qty_q[2:0]), 4'h0};
		if (exc_q != `MPA_EX_NONE) begin
			tx_frame = {fc_q | `MPA_FC_EXC, exc_q, 88'h0};
			tx_len   = `MPA_LEN_EXC;
		end else if (is_read) begin
			tx_frame = {fc_q, {qty_q[6:0], 1'b0}, rd_aligned, 24'h0};
			tx_len   = `MPA_LEN_RHDR + {qty_q[2:0], 1'b0};
		end else begin
			tx_frame = {fc_q, addr_q, qty_q, 64'h0};
			tx_len   = `MPA_LEN_ECHO;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			fc_q    <= 8'h00;
			addr_q  <= 16'h0000;
			qty_q   <= 16'h0000;
			bc_q    <= 8'h00;
			data_q  <= 64'h0;
			conn_q  <= 2'h0;
			drop_q  <= 1'b0;
			float_q <= 1'b0;
			we_q    <= 1'b0;
			exec_q  <= 1'b0;
			exc_q   <= 8'h00;
			wdata_q <= 64'h0;
			rdata_q <= 64'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			fc_q    <= fc_d;
			addr_q  <= addr_d;
			qty_q   <= qty_d;
			bc_q    <= bc_d;
			data_q  <= data_d;
			conn_q  <= conn_d;
			drop_q  <= drop_d;
			float_q <= float_d;
			we_q    <= we_d;
			exec_q  <= exec_d;
			exc_q   <= exc_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
		end
	end

	// Lookup and access requests; a write rejected by the checks or the lookup never reaches the access state
	assign look_req_o  = (state_q == ST_LOOK);
	assign look_addr_o = addr_q;
	assign acc_req_o   = (state_q == ST_ACC);
	assign acc_we_o    = we_q;
	assign acc_exec_o  = exec_q;
	assign acc_addr_o  = addr_q;
	assign acc_wdata_o = wdata_q;

	// Float write scaling
	mpa_div1000 u_div (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.start_i    (div_start),
		.dividend_i (mpa_sext(data_q, qty_q)),
		.done_o     (div_done),
		.quot_o     (div_quot)
	);

	// Response serializer, tagged with the requesting connection
	mpa_tx u_tx (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.load_i     (tx_load),
		.len_i      (tx_len),
		.frame_i    (tx_frame),
		.conn_i     (conn_q),
		.done_o     (tx_done),
		.tx_valid_o (tx_valid_o),
		.tx_data_o  (tx_data_o),
		.tx_last_o  (tx_last_o),
		.tx_conn_o  (tx_conn_o),
		.tx_ready_i (tx_ready_i)
	);

endmodule

// *** test/mpa_top_properties.sv ***
`timescale 1ns/100ps
`include "mpa_defs.svh"

// Protocol checks on the handler ports; a single clock domain
module mpa_top_properties (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        rx_valid_i,
	input wire logic [7:0]  rx_data_i,
	input wire logic        rx_last_i,
	input wire logic [1:0]  rx_conn_i,
	input wire logic [15:0] rx_port_i,
	input wire logic        rx_ready_o,
	input wire logic        tx_valid_o,
	input wire logic [7:0]  tx_data_o,
	input wire logic        tx_last_o,
	input wire logic        tx_ready_i,
	input wire logic        look_req_o,
	input wire logic [15:0] look_addr_o,
	input wire logic        look_ack_i,
	input wire logic        acc_req_o,
	input wire logic        acc_we_o,
	input wire logic        acc_exec_o,
	input wire logic [15:0] acc_addr_o,
	input wire logic        acc_ack_i
);
	logic [3:0] idx_q, idx_d;
	logic [7:0] fc_q, fc_d, bc_q, bc_d;
	logic       first_q, first_d;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// Track response byte position and the request frame start
	always_comb begin
		idx_d = idx_q;
		fc_d = fc_q;
		bc_d = bc_q;
		first_d = first_q;
		if (tx_valid_o && tx_ready_i) begin
			if (idx_q == 4'h0) fc_d = tx_data_o;
			if (idx_q == 4'h1) bc_d = tx_data_o;
			idx_d = tx_last_o ? 4'h0 : idx_q + 4'h1;
		end
		if (rx_valid_i && rx_ready_o) first_d = rx_last_i;
	end

	// Position state must restart cleanly after any reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			idx_q <= 4'h0;
			fc_q <= 8'h00;
			bc_q <= 8'h00;
			first_q <= 1'b1;
		end else begin
			idx_q <= idx_d;
			fc_q <= fc_d;
			bc_q <= bc_d;
			first_q <= first_d;
		end
	end

	fc_byte_a: assert property (tx_valid_o && idx_q == 4'h0 |->
		tx_data_o[7] || tx_data_o inside {`MPA_FC_READ, `MPA_FC_WRITE})
		else $error("bad function byte");
	exc_code_a: assert property (tx_valid_o && idx_q == 4'h1 && fc_q[7] |-> tx_last_o &&
		tx_data_o inside {[8'h01:8'h06], 8'h08, 8'h0a, 8'h0b, [8'h20:8'h23]})
		else $error("bad exception code");
	rd_count_a: assert property (tx_valid_o && idx_q == 4'h1 && fc_q == 8'h03 |->
		tx_data_o inside {8'h02, 8'h04, 8'h08}) else $error("bad byte count");
	rd_length_a: assert property (tx_valid_o && tx_last_o && fc_q == 8'h03 |->
		idx_q == bc_q[3:0] + 4'h1) else $error("read reply length");
	wr_echo_a: assert property (tx_valid_o && tx_last_o && fc_q == 8'h10 |-> idx_q == 4'h4)
		else $error("write echo length");
	bad_fc_fast_a: assert property (rx_valid_i && rx_ready_o && rx_last_i && first_q &&
		rx_port_i == `MPA_TCP_PORT && rx_conn_i != 2'h3 &&
		!(rx_data_i inside {8'h03, 8'h10}) |-> ##[1:4] tx_valid_o) else $error("no quick answer");
	look_hold_a: assert property (look_req_o && !look_ack_i |=>
		look_req_o && $stable(look_addr_o)) else $error("lookup dropped");
	acc_hold_a: assert property (acc_req_o && !acc_ack_i |=>
		acc_req_o && $stable(acc_addr_o) && $stable(acc_we_o)) else $error("access dropped");
	exec_nowe_a: assert property (acc_req_o && acc_exec_o |-> !acc_we_o)
		else $error("exec with write");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_data_o)) else $error("byte changed");

	read_c: cover property (tx_valid_o && tx_last_o && fc_q == 8'h03);
	write_c: cover property (tx_valid_o && tx_last_o && fc_q == 8'h10);
	exc_c: cover property (tx_valid_o && idx_q == 4'h1 && fc_q[7]);
endmodule

bind mpa_top mpa_top_properties chk (.*);

// *** test/mpa_store_model.sv ***
`timescale 1ns/100ps

// Parameter store behind the handler; lat sets the answer delay in cycles.
// Ports keep the handler's names so the bench can join them by name.
module mpa_store_model (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic [1:0]  lat,
	input wire logic        look_req_o,
	input wire logic [15:0] look_addr_o,
	input wire logic        acc_req_o,
	input wire logic        acc_we_o,
	input wire logic        acc_exec_o,
	input wire logic [15:0] acc_addr_o,
	input wire logic [63:0] acc_wdata_o,
	output logic            look_ack_i,
	output logic            look_found_i,
	output logic            look_wide_i,
	output logic            look_single_i,
	output logic            look_float_i,
	output logic            look_cmd_i,
	output logic            look_string_i,
	output logic            acc_ack_i,
	output logic            acc_err_i,
	output logic [63:0]     acc_rdata_i
);
	logic [1:0]  lc, ac;
	logic [5:0]  attr;
	logic [63:0] r;
	logic [63:0] v7a = 64'h0;
	logic [63:0] v10 = 64'h5;
	logic [63:0] v24c = 64'h000000012a05f200;
	int          execs = 0;

	// Attributes: found, wide, single, float, cmd, string; inverted when unqualified
	always_comb begin
		case (look_addr_o)
			16'h024c: attr = 6'b110000;
			16'h007a: attr = 6'b101000;
			16'h0040: attr = 6'b100000;
			16'h0010: attr = 6'b100100;
			16'h0020: attr = 6'b100010;
			16'h0030: attr = 6'b100001;
			default: attr = 6'h00;
		endcase
		look_ack_i = look_req_o && lc == lat;
		{look_found_i, look_wide_i, look_single_i, look_float_i, look_cmd_i,
			look_string_i} = look_ack_i ? attr : ~attr;
		case (acc_addr_o)
			16'h0020: r = 64'h77;
			16'h007a: r = v7a;
			16'h0010: r = v10;
			16'h024c: r = v24c;
			default: r = 64'h0;
		endcase
		acc_ack_i = acc_req_o && ac == lat;
		acc_err_i = acc_ack_i ? acc_we_o && acc_addr_o == 16'h0040 : 1'b1;
		acc_rdata_i = acc_ack_i ? r : ~r;
	end

	// Delay counters restart on reset; stored values survive it like real memory
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lc <= 2'h0;
			ac <= 2'h0;
		end else begin
			lc <= (look_req_o && !look_ack_i) ? lc + 2'h1 : 2'h0;
			ac <= (acc_req_o && !acc_ack_i) ? ac + 2'h1 : 2'h0;
			if (acc_ack_i && acc_we_o && acc_addr_o == 16'h007a) v7a <= acc_wdata_o;
			if (acc_ack_i && acc_we_o && acc_addr_o == 16'h0010) v10 <= acc_wdata_o;
			if (acc_ack_i && acc_we_o && acc_addr_o == 16'h024c) v24c <= acc_wdata_o;
			if (acc_ack_i && acc_exec_o) execs <= execs + 1;
		end
	end
endmodule

// *** test/modbus_parameter_access_handler_tb_top.sv ***
`timescale 1ns/100ps
`include "mpa_defs.svh"

module modbus_parameter_access_handler_tb_top;
	import mpa_pkg::*;
	typedef struct {int rl; logic [79:0] rq; int el; logic [79:0] ex;} mpa_row_type;
	logic        clk_i, rstn_i, rx_valid_i, rx_last_i, tx_ready_i;
	logic [7:0]  rx_data_i, tx_data_o;
	logic [1:0]  rx_conn_i, tx_conn_o, lat;
	logic [15:0] rx_port_i, look_addr_o, acc_addr_o;
	logic        rx_ready_o, tx_valid_o, tx_last_o, look_req_o, acc_req_o, acc_we_o;
	logic        acc_exec_o, look_ack_i, look_found_i, look_wide_i, look_single_i;
	logic        look_float_i, look_cmd_i, look_string_i, acc_ack_i, acc_err_i;
	logic [63:0] acc_wdata_o, acc_rdata_i;
	int          bad_count = 0;
	int          compares = 0;
	int          n;
	mpa_row_type rows[18] = '{
		'{5, 80'h03024c0004, 10, 80'h0308000000012a05f200},
		'{10, 80'h10007a00020400000003, 5, 80'h10007a0002},
		'{10, 80'h10007a00020600000009, 2, 80'h9023},
		'{5, 80'h03007a0002, 6, 80'h030400000003},
		'{5, 80'h03007a0001, 4, 80'h03020003},
		'{5, 80'h03007a0003, 2, 80'h8320},
		'{5, 80'h0300100002, 6, 80'h030400001388},
		'{10, 80'h10001000020400001f40, 5, 80'h1000100002},
		'{5, 80'h0300100002, 6, 80'h030400001f40},
		'{5, 80'h0300200002, 6, 80'h030400000000},
		'{10, 80'h10002000020412345678, 5, 80'h1000200002},
		'{1, 80'h04, 2, 80'h8401},
		'{5, 80'h0301000002, 2, 80'h8321},
		'{5, 80'h0300300002, 2, 80'h8321},
		'{10, 80'h10004000020400000001, 2, 80'h9022},
		'{4, 80'h03024c00, 2, 80'h8303},
		'{10, 80'h10024c00020400000001, 2, 80'h9020},
		'{5, 80'h03024c0004, 10, 80'h0308000000012a05f200}
	};

	mpa_top uut (.*);
	mpa_store_model store (.*);

	// Free-running 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic final_report();
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Inputs change 1 ns after the rising edge
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask

	// Offer one request byte per accepted edge; a stuck ready ends the run
	task automatic send(input mpa_row_type r, input logic [15:0] port, input logic [1:0] c);
		for (int i = 0; i < r.rl; i++) begin
			rx_valid_i = 1'b1;
			rx_data_i = r.rq[8*(r.rl-1-i) +: 8];
			rx_last_i = (i == r.rl - 1);
			rx_port_i = port;
			rx_conn_i = c;
			for (n = 0; !rx_ready_o && n < 400; n++) tick();
			if (n == 400) begin
				bad_count++;
				final_report();
			end
			tick();
		end
		rx_valid_i = 1'b0;
		rx_last_i = 1'b0;
	endtask

	// Take the reply, stalling odd bytes one cycle so they must stand
	task automatic recv(input mpa_row_type r, input logic [1:0] c);
		for (int i = 0; i < r.el; i++) begin
			for (n = 0; !tx_valid_o && n < 400; n++) tick();
			if (n == 400) begin
				bad_count++;
				final_report();
			end
			if (i % 2 == 1) begin
				tx_ready_i = 1'b0;
				tick();
			end
			tx_ready_i = 1'b1;
			check(tx_data_o, r.ex[8*(r.el-1-i) +: 8]);
			check(tx_last_o, i == r.el - 1);
			check(tx_conn_o, c);
			tick();
		end
		tx_ready_i = 1'b0;
	endtask

	// Dropped frames must leave the output silent
	task automatic silent(input logic [15:0] port, input logic [1:0] c);
		send(rows[0], port, c);
		n = 0;
		repeat (100) begin
			n += tx_valid_o;
			tick();
		end
		check(n, 0);
	endtask

	initial begin
		{rstn_i, rx_valid_i, rx_last_i, tx_ready_i, rx_data_i, rx_conn_i, lat} = '0;
		rx_port_i = `MPA_TCP_PORT;
		repeat (6) @(posedge clk_i);
		#1 rstn_i = 1'b1;
		for (int k = 0; k < 18; k++) begin
			lat = 2'(k % 3);
			send(rows[k], `MPA_TCP_PORT, 2'(k % 3));
			recv(rows[k], 2'(k % 3));
		end
		check(store.v10, 64'h8);
		check(store.execs, 1);
		check(store.v7a, 64'h3);
		silent(16'h01f7, 2'h0);
		silent(`MPA_TCP_PORT, 2'h3);
		// Reset in mid-run, then the handler must serve again
		rstn_i = 1'b0;
		tick();
		check({rx_ready_o, tx_valid_o, look_req_o, acc_req_o}, 4'h8);
		repeat (6) tick();
		rstn_i = 1'b1;
		send(rows[1], `MPA_TCP_PORT, 2'h2);
		recv(rows[1], 2'h2);
		final_report();
	end
endmodule
